// ===== common/ctd_pkg.sv
// constants for the two-channel cycle-steal transfer controller
package ctd_pkg;
   // register bus geometry
   localparam int CTD_ADDR_W = 12;
   localparam logic [5:0] CTD_PAGE_HI = 6'h00;
   // per-channel register offsets, channel one adds the stride
   localparam logic [4:0] CTD_OFF_SRC = 5'h00;
   localparam logic [4:0] CTD_OFF_DST = 5'h04;
   localparam logic [4:0] CTD_OFF_RELOAD = 5'h08;
   localparam logic [4:0] CTD_OFF_CTRL = 5'h0C;
   localparam logic [4:0] CTD_OFF_COUNT = 5'h10;
   localparam logic [4:0] CTD_OFF_SWREQ = 5'h14;
   localparam logic [5:0] CTD_CHAN_STRIDE = 6'h20;
   // control register field positions
   localparam int CTD_CTRL_EN = 0;
   localparam int CTD_CTRL_UNIT16 = 1;
   localparam int CTD_CTRL_REPEAT = 2;
   localparam int CTD_CTRL_SRCFWD = 3;
   localparam int CTD_CTRL_DSTFWD = 4;
   localparam int CTD_CTRL_SEL_LO = 8;
   localparam int CTD_SWREQ_BIT = 0;
   localparam int CTD_COUNT_PEND = 16;
   localparam int CTD_COUNT_FIRST = 17;
   // reset values
   localparam logic [19:0] CTD_PTR_RST = 20'h00000;
   localparam logic [15:0] CTD_CNT_RST = 16'h0000;
   localparam logic [3:0] CTD_SEL_RST = 4'h0;
   // trigger select codes
   localparam logic [3:0] CTD_SEL_SOFT = 4'h0;
   localparam logic [3:0] CTD_SEL_EXT = 4'h1;
   localparam logic [3:0] CTD_SEL_PERI_LO = 4'h2;
   localparam logic [3:0] CTD_SEL_SER1 = 4'hC;
   localparam int CTD_PERI_N = 15;
   localparam int CTD_PERI_SER1TX = 10;
   localparam int CTD_PERI_SER1RX = 11;
   // own register block, never a transfer target
   localparam logic [19:0] CTD_PROT_LO = 20'h00020;
   localparam logic [19:0] CTD_PROT_HI = 20'h0003F;
   // bus responses
   localparam logic [1:0] CTD_RESP_OKAY = 2'h0;
   localparam logic [1:0] CTD_RESP_SLVERR = 2'h2;
   // engine states
   typedef enum logic [1:0] {CTD_IDLE, CTD_READ, CTD_WRITE, CTD_DONE} ctd_state_e;
endpackage

// ===== design/ctd_dma.sv
// two-channel cycle-steal transfer controller with AXI4-Lite registers
// Overview of operation
// - two independent channels share one data bus, stealing single bus cycles.
// - controller bus requests win over the CPU; transfers go ahead of it.
// - each request moves one unit: a 16-bit word or an 8-bit byte.
// - requests come from software request writes or the selected interrupt signal.
// - triggers ignore CPU interrupt masking; transfers never clear interrupt requests.
// - enabled channel transfers once per request; disabled channel ignores requests.
// - requests faster than transfers merge into one pending request.
// - patterns: any-to-fixed, fixed-to-any, fixed-to-fixed over 1M bytes.
// - own register range 0x20..0x3F is never a transfer source or destination.
// - source and destination both forward is illegal; software must avoid it.
// - sixteen-bit unit counter gives 128K bytes word mode, 64K byte mode.
// - external input zero falling edge triggers channel zero, input one channel one.
// - both channels take timer, serial, converter and software triggers.
// - serial one transmit only for channel zero, receive only for channel one.
// - simultaneous requests: channel zero served first, then channel one.
// - single mode underflow clears enable, channel stays idle until set again.
// - repeat mode underflow reloads counter, channel stays active until disabled.
// - every counter underflow raises the channel transfer-complete request.
// - first transfer after activation loads forward pointer and counter.
// - forward pointer registers always writable; fixed ones only while disabled.
// - registers always readable; enabled forward register reads the live pointer.
`timescale 1ns/100ps
`default_nettype none
module ctd_dma
   import ctd_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // AXI4-Lite register slave
   input wire logic [CTD_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [CTD_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // trigger sources
   input wire logic extIrqInZeroN,
   input wire logic extIrqInOneN,
   input wire logic [CTD_PERI_N-1:0] periIrq,
   // shared memory bus, cycle-steal master
   output logic cpuHold,
   output logic memReq,
   output logic memWrite,
   output logic memWord,
   output logic [19:0] memAddr,
   output logic [15:0] memWdata,
   input wire logic memAck,
   input wire logic [15:0] memRdata,
   // transfer-complete requests, one per channel
   output logic [1:0] xferDone
);

   // reset release through two flops
   logic rstMeta_r, rstSync_r;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end
   wire logic rstN = rstSync_r;

   // channel state
   logic [19:0] srcPtr_r [2];
   logic [19:0] dstPtr_r [2];
   logic [19:0] fwdPtr_r [2];
   logic [CNT_W-1:0] reload_r [2];
   logic [CNT_W-1:0] cnt_r [2];
   logic [1:0] en_r, unit16_r, repeat_r, srcFwd_r, dstFwd_r, first_r, pend_r;
   logic [3:0] sel_r [2];

   // engine state
   ctd_state_e state_r;
   logic engCh_r;
   logic [19:0] engSrc_r, engDst_r, engPtr_r;
   logic [CNT_W-1:0] engCnt_r;
   logic [15:0] engData_r;

   // pins are asynchronous: two flops, third for the edge
   logic [1:0] extMeta_r, extSync_r, extPrev_r;
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         extMeta_r <= 2'b11;
         extSync_r <= 2'b11;
         extPrev_r <= 2'b11;
      end else begin
         extMeta_r <= {extIrqInOneN, extIrqInZeroN};
         extSync_r <= extMeta_r;
         extPrev_r <= extSync_r;
      end
   end
   wire logic [1:0] extFall = extPrev_r & ~extSync_r;

   // peripheral requests are same-clock; look at rising edges only,
   // the request bits themselves are never touched
   logic [CTD_PERI_N-1:0] periPrev_r;
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) periPrev_r <= '0;
      else periPrev_r <= periIrq;
   end
   wire logic [CTD_PERI_N-1:0] periRise = periIrq & ~periPrev_r;

   // hardware trigger of one channel from its select code
   function automatic logic hwTrig(input logic ch, input logic [3:0] sel,
                                   input logic [1:0] ext, input logic [CTD_PERI_N-1:0] pr);
      logic r;
      r = 1'b0;
      if (sel == CTD_SEL_SOFT) r = 1'b0;
      else if (sel == CTD_SEL_EXT) r = ext[ch];
      else if (sel == CTD_SEL_SER1) r = ch ? pr[CTD_PERI_SER1RX] : pr[CTD_PERI_SER1TX];
      else if (sel < CTD_SEL_SER1) r = pr[4'(sel - CTD_SEL_PERI_LO)];
      else r = pr[4'(sel - 4'h1)];
      return r;
   endfunction

   // inside the controller's own register block
   function automatic logic isProt(input logic [19:0] a);
      return (a >= CTD_PROT_LO) && (a <= CTD_PROT_HI);
   endfunction

   // register decode shared by read and write
   function automatic logic regHit(input logic [CTD_ADDR_W-1:0] a);
      logic [4:0] o;
      o = a[4:0];
      return (a[CTD_ADDR_W-1:6] == CTD_PAGE_HI[CTD_ADDR_W-7:0]) && (o == CTD_OFF_SRC || o == CTD_OFF_DST ||
             o == CTD_OFF_RELOAD || o == CTD_OFF_CTRL || o == CTD_OFF_COUNT || o == CTD_OFF_SWREQ);
   endfunction

   // byte-lane merge for writes
   function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] st);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) m[i*8 +: 8] = d[i*8 +: 8];
      end
      return m;
   endfunction

   // AXI write channels: address and data may arrive in either order
   logic awHave_r, wHave_r;
   logic [CTD_ADDR_W-1:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         awHave_r <= 1'b0;
         wHave_r <= 1'b0;
         awAddr_r <= '0;
         wData_r <= 32'h00000000;
         wStrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CTD_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (awHave_r && wHave_r && !s_axi_bvalid) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= regHit(awAddr_r) ? CTD_RESP_OKAY : CTD_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // ready only while the slot is empty, so registers act as skid
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !awHave_r && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !wHave_r && !(s_axi_wvalid && s_axi_wready);
      end
   end
   wire logic doWrite = awHave_r && wHave_r && !s_axi_bvalid;
   wire logic wrCh = awAddr_r[5];
   wire logic [4:0] wrOff = awAddr_r[4:0];

   // read data mux
   function automatic logic [31:0] rdVal(input logic ch, input logic [4:0] o);
      logic [31:0] v;
      v = 32'h00000000;
      unique case (o)
         CTD_OFF_SRC: v[19:0] = (en_r[ch] && srcFwd_r[ch]) ? fwdPtr_r[ch] : srcPtr_r[ch];
         CTD_OFF_DST: v[19:0] = (en_r[ch] && dstFwd_r[ch]) ? fwdPtr_r[ch] : dstPtr_r[ch];
         CTD_OFF_RELOAD: v[CNT_W-1:0] = reload_r[ch];
         CTD_OFF_CTRL: begin
            v[CTD_CTRL_EN] = en_r[ch];
            v[CTD_CTRL_UNIT16] = unit16_r[ch];
            v[CTD_CTRL_REPEAT] = repeat_r[ch];
            v[CTD_CTRL_SRCFWD] = srcFwd_r[ch];
            v[CTD_CTRL_DSTFWD] = dstFwd_r[ch];
            v[CTD_CTRL_SEL_LO +: 4] = sel_r[ch];
         end
         CTD_OFF_COUNT: begin
            v[CNT_W-1:0] = cnt_r[ch];
            v[CTD_COUNT_PEND] = pend_r[ch];
            v[CTD_COUNT_FIRST] = first_r[ch];
         end
         default: v = 32'h00000000;
      endcase
      return v;
   endfunction

   // AXI read: one cycle from address to data
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= CTD_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= regHit(s_axi_araddr) ? rdVal(s_axi_araddr[5], s_axi_araddr[4:0]) : 32'h00000000;
            s_axi_rresp <= regHit(s_axi_araddr) ? CTD_RESP_OKAY : CTD_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // arbitration: channel zero wins a tie
   wire logic grant0 = pend_r[0] && en_r[0];
   wire logic grant1 = pend_r[1] && en_r[1] && !grant0;
   wire logic startXfer = (state_r == CTD_IDLE) && (grant0 || grant1);
   wire logic startCh = !grant0;
   wire logic [19:0] startPtr = first_r[startCh] ? (srcFwd_r[startCh] ? srcPtr_r[startCh] : dstPtr_r[startCh])
                                                : fwdPtr_r[startCh];
   wire logic [CNT_W-1:0] startCnt = first_r[startCh] ? reload_r[startCh] : cnt_r[startCh];
   wire logic finish = state_r == CTD_DONE;
   wire logic underflow = engCnt_r == '0;
   wire logic [19:0] stepPtr = engPtr_r + (unit16_r[engCh_r] ? 20'h00002 : 20'h00001);

   // per-channel register and live state; hardware end of single mode wins
   // over a same-cycle software write so the channel cannot restart silently
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         for (int c = 0; c < 2; c++) begin
            srcPtr_r[c] <= CTD_PTR_RST;
            dstPtr_r[c] <= CTD_PTR_RST;
            fwdPtr_r[c] <= CTD_PTR_RST;
            reload_r[c] <= CTD_CNT_RST;
            cnt_r[c] <= CTD_CNT_RST;
            sel_r[c] <= CTD_SEL_RST;
         end
         en_r <= 2'b00;
         unit16_r <= 2'b00;
         repeat_r <= 2'b00;
         srcFwd_r <= 2'b00;
         dstFwd_r <= 2'b00;
         first_r <= 2'b00;
         pend_r <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            // consumed request cleared first, new triggers set after
            if (startXfer && startCh == c[0]) pend_r[c] <= 1'b0;
            if (startXfer && startCh == c[0]) first_r[c] <= 1'b0;
            if (!en_r[c]) pend_r[c] <= 1'b0;
            if (doWrite && wrCh == c[0]) begin
               unique case (wrOff)
                  CTD_OFF_SRC:
                     if (srcFwd_r[c] || !en_r[c])
                        srcPtr_r[c] <= 20'(laneMerge({12'h000, srcPtr_r[c]}, wData_r, wStrb_r));
                  CTD_OFF_DST:
                     if (dstFwd_r[c] || !en_r[c])
                        dstPtr_r[c] <= 20'(laneMerge({12'h000, dstPtr_r[c]}, wData_r, wStrb_r));
                  CTD_OFF_RELOAD:
                     reload_r[c] <= CNT_W'(laneMerge({{(32-CNT_W){1'b0}}, reload_r[c]}, wData_r, wStrb_r));
                  CTD_OFF_CTRL: begin
                     if (wStrb_r[0]) begin
                        en_r[c] <= wData_r[CTD_CTRL_EN];
                        if (wData_r[CTD_CTRL_EN] && !en_r[c]) first_r[c] <= 1'b1;
                        unit16_r[c] <= wData_r[CTD_CTRL_UNIT16];
                        repeat_r[c] <= wData_r[CTD_CTRL_REPEAT];
                        srcFwd_r[c] <= wData_r[CTD_CTRL_SRCFWD];
                        // both forward is illegal: source keeps it
                        dstFwd_r[c] <= wData_r[CTD_CTRL_DSTFWD] && !wData_r[CTD_CTRL_SRCFWD];
                     end
                     if (wStrb_r[1]) sel_r[c] <= wData_r[CTD_CTRL_SEL_LO +: 4];
                  end
                  CTD_OFF_SWREQ:
                     if (wStrb_r[0] && wData_r[CTD_SWREQ_BIT] && en_r[c]) pend_r[c] <= 1'b1;
                  default: ;
               endcase
            end
            // a trigger merges into any request still pending
            if (en_r[c] && hwTrig(c[0], sel_r[c], extFall, periRise)) pend_r[c] <= 1'b1;
            if (finish && engCh_r == c[0]) begin
               fwdPtr_r[c] <= stepPtr;
               if (underflow) begin
                  cnt_r[c] <= reload_r[c];
                  if (!repeat_r[c]) begin
                     en_r[c] <= 1'b0;
                     pend_r[c] <= 1'b0;
                  end
               end else begin
                  cnt_r[c] <= engCnt_r - 1'b1;
               end
            end
         end
      end
   end

   // transfer engine: read source, then write destination
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         state_r <= CTD_IDLE;
         engCh_r <= 1'b0;
         engSrc_r <= CTD_PTR_RST;
         engDst_r <= CTD_PTR_RST;
         engPtr_r <= CTD_PTR_RST;
         engCnt_r <= CTD_CNT_RST;
         engData_r <= 16'h0000;
      end else begin
         unique case (state_r)
            CTD_IDLE:
               if (startXfer) begin
                  engCh_r <= startCh;
                  engPtr_r <= startPtr;
                  engCnt_r <= startCnt;
                  engSrc_r <= srcFwd_r[startCh] ? startPtr : srcPtr_r[startCh];
                  engDst_r <= dstFwd_r[startCh] ? startPtr : dstPtr_r[startCh];
                  state_r <= CTD_READ;
               end
            CTD_READ:
               if (isProt(engSrc_r)) begin
                  engData_r <= 16'h0000;
                  state_r <= CTD_WRITE;
               end else if (memAck) begin
                  engData_r <= memRdata;
                  state_r <= CTD_WRITE;
               end
            CTD_WRITE:
               if (isProt(engDst_r) || memAck) state_r <= CTD_DONE;
            CTD_DONE:
               state_r <= CTD_IDLE;
         endcase
      end
   end

   // bus master outputs, registered; the CPU is held for the whole unit
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         cpuHold <= 1'b0;
         memReq <= 1'b0;
         memWrite <= 1'b0;
         memWord <= 1'b0;
         memAddr <= 20'h00000;
         memWdata <= 16'h0000;
      end else begin
         cpuHold <= startXfer || (state_r != CTD_IDLE && !finish && !(state_r == CTD_WRITE &&
                    (isProt(engDst_r) || memAck)));
         if (startXfer) begin
            memReq <= !isProt(srcFwd_r[startCh] ? startPtr : srcPtr_r[startCh]);
            memWrite <= 1'b0;
            memWord <= unit16_r[startCh];
            memAddr <= srcFwd_r[startCh] ? startPtr : srcPtr_r[startCh];
         end else if (state_r == CTD_READ && (isProt(engSrc_r) || memAck)) begin
            memReq <= !isProt(engDst_r);
            memWrite <= 1'b1;
            memAddr <= engDst_r;
            memWdata <= isProt(engSrc_r) ? 16'h0000 : memRdata;
         end else if (state_r == CTD_WRITE && memAck) begin
            memReq <= 1'b0;
            memWrite <= 1'b0;
         end
      end
   end

   // transfer-complete pulse on each underflow
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) xferDone <= 2'b00;
      else begin
         xferDone[0] <= finish && underflow && !engCh_r;
         xferDone[1] <= finish && underflow && engCh_r;
      end
   end

endmodule
`default_nettype wire

// ===== tb/ctd_dma_asserts.sv
// concurrent checks on the memory-side ports of the transfer controller
`timescale 1ns/100ps
`default_nettype none
module ctd_dma_asserts
   import ctd_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // cycle-steal bus and completion pulses
   input wire logic cpuHold,
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic memWord,
   input wire logic [19:0] memAddr,
   input wire logic [15:0] memWdata,
   input wire logic memAck,
   input wire logic [15:0] memRdata,
   input wire logic [1:0] xferDone
);
   // one domain, so reset gates every check in one place
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // an access holds still until the partner acknowledges it
   chk_req_stable: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWrite))
      else $error("bus request changed before acknowledge");
   chk_bus_owned: assert property (memReq |-> cpuHold)
      else $error("bus access without holding the processor");
   chk_read_first: assert property (memReq && !memWrite && memAck |=> !memReq || memWrite)
      else $error("read not followed by the write");
   chk_byte_copy: assert property (memReq && !memWrite && memAck |=> !memReq || memWdata[7:0] == $past(memRdata[7:0]))
      else $error("written byte differs from read byte");
   chk_word_copy: assert property (memReq && !memWrite && memAck && memWord |=> !memReq || memWdata == $past(memRdata))
      else $error("written word differs from read word");
   chk_no_own_regs: assert property (memReq |-> !(memAddr inside {[CTD_PROT_LO:CTD_PROT_HI]}))
      else $error("access to the controller own register range");
   chk_unit_end: assert property (memReq && memWrite && memAck |=> !memReq && !cpuHold)
      else $error("bus not released after one unit");
   chk_done_pulse: assert property (|xferDone |=> xferDone == 2'h0 ##1 xferDone == 2'h0)
      else $error("completion pulse longer than one cycle");
   // main scenarios seen
   cov_unit: cover property (memReq && memWrite && memAck);
   cov_done_zero: cover property (xferDone[0]);
   cov_done_one: cover property (xferDone[1]);
endmodule
bind ctd_dma ctd_dma_asserts i_ctd_dma_asserts (.*);
`default_nettype wire

// ===== tb/ctd_mem_model.sv
// memory partner answering the cycle-steal master, with a write log
`timescale 1ns/100ps
`default_nettype none
module ctd_mem_model (
   // clock and answer delay
   input wire logic sys_clk,
   input wire logic [1:0] slowDly,
   // cycle-steal bus
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic [19:0] memAddr,
   input wire logic [15:0] memWdata,
   output logic memAck,
   output logic [15:0] memRdata,
   // write log for the bench
   output logic [7:0] wrCount,
   output logic [19:0] lastAddr,
   output logic [15:0] lastData
);
   logic [1:0] waitCnt;
   initial begin
      memAck = 1'b0;
      memRdata = 16'h0000;
      wrCount = 8'h00;
      waitCnt = 2'h0;
   end
   // read data toggles outside an answer so a late sample cannot match by luck
   always @(posedge sys_clk) begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memReq && !memAck) begin
         if (waitCnt != slowDly) begin
            waitCnt <= waitCnt + 2'h1;
         end else begin
            waitCnt <= 2'h0;
            memAck <= 1'b1;
            memRdata <= memAddr[15:0] ^ 16'h5A5A;
            if (memWrite) begin
               wrCount <= wrCount + 8'h01;
               lastAddr <= memAddr;
               lastData <= memWdata;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/ctd_dma_test.sv
// self-checking bench for the two-channel cycle-steal transfer controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin \
   cmpCount++; \
   if ((a) !== (b)) begin \
      badCount++; \
      $display("mismatch at %0t got %0h expected %0h", $time, a, b); \
   end \
end
module ctd_dma_test;
   import ctd_pkg::*;
   logic sys_clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpuHold, memReq, memWrite;
   logic memWord, memAck;
   logic rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, extIrqInZeroN = 1'b1, extIrqInOneN = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [14:0] periIrq = 15'h0;
   logic [1:0] slowDly = 2'h0, s_axi_bresp, s_axi_rresp, xferDone;
   logic [19:0] memAddr, lastAddr;
   logic [15:0] memWdata, memRdata, lastData, rnd = 16'h0062;
   logic [7:0] wrCount;
   int badCount = 0, cmpCount = 0, cyc = 0;
   int doneCnt[2] = '{0, 0};
   ctd_dma #(.CNT_W(16)) i_ctd_dma (.*);
   ctd_mem_model i_ctd_mem_model (.*);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // completion pulses counted, and a hung run cut short
   always @(posedge sys_clk) begin
      cyc++;
      doneCnt[0] += int'(xferDone[0]);
      doneCnt[1] += int'(xferDone[1]);
      if (cyc == 20000) begin
         badCount++;
         wrapUp();
      end
   end
   task automatic wrapUp();
      if (badCount == 0 && cmpCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   function automatic logic [11:0] ra(input int ch, input logic [4:0] off);
      return 12'(ch * 32) + 12'(off);
   endfunction
   function automatic logic [15:0] pat(input logic [19:0] a);
      return a[15:0] ^ 16'h5A5A;
   endfunction
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // bus master: hold each channel until its own ready
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // bounded wait for the partner's write log to reach a count
   task automatic waitN(input logic [7:0] n);
      int k;
      k = 0;
      while (wrCount !== n && k < 80) begin
         @(posedge sys_clk);
         k++;
      end
   endtask
   task automatic pulse(input int idx);
      @(posedge sys_clk);
      periIrq[idx] <= 1'b1;
      @(posedge sys_clk);
      periIrq[idx] <= 1'b0;
   endtask
   // disable first, since fixed pointers only take writes while idle
   task automatic setup(input int ch, input logic [19:0] s, input logic [19:0] d, input logic [15:0] rl,
                        input logic [31:0] c);
      axw(ra(ch, CTD_OFF_CTRL), 32'h0);
      axw(ra(ch, CTD_OFF_SRC), {12'h000, s});
      axw(ra(ch, CTD_OFF_DST), {12'h000, d});
      axw(ra(ch, CTD_OFF_RELOAD), {16'h0000, rl});
      axw(ra(ch, CTD_OFF_CTRL), c);
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [19:0] src;
      logic [15:0] rl;
      logic [7:0] base;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      axr(12'h018, d, r);
      `CHK(r, CTD_RESP_SLVERR)
      // single mode, bytes, source forward, random start and length
      rnd = lfsr(rnd);
      src = {4'h1, rnd};
      rnd = lfsr(rnd);
      rl = {14'h0, rnd[1:0]} + 16'h1;
      setup(0, src, 20'h00100, rl, 32'h9);
      for (int i = 0; i <= int'(rl); i++) begin
         axw(ra(0, CTD_OFF_SWREQ), 32'h1);
         waitN(8'(i + 1));
         `CHK(wrCount, 8'(i + 1))
         `CHK(lastAddr, 20'h00100)
         `CHK(lastData[7:0], 8'(pat(src + 20'(i))))
         if (i == 0) begin
            axr(ra(0, CTD_OFF_SRC), d, r);
            `CHK(d[19:0], src + 20'h1)
            axw(ra(0, CTD_OFF_DST), 32'h200);
            axr(ra(0, CTD_OFF_DST), d, r);
            `CHK(d[19:0], 20'h00100)
         end
      end
      axr(ra(0, CTD_OFF_CTRL), d, r);
      `CHK(d[0], 1'b0)
      `CHK(doneCnt[0], 1)
      axw(ra(0, CTD_OFF_SWREQ), 32'h1);
      waitN(wrCount + 8'h1);
      `CHK(wrCount, 8'(rl + 16'h1))
      // one peripheral line feeds both channels: channel zero goes first
      setup(0, 20'h10000, 20'h00300, 16'h0000, 32'h203);
      setup(1, 20'h10010, 20'h00400, 16'h0000, 32'h217);
      base = wrCount;
      pulse(0);
      waitN(base + 8'h1);
      `CHK(lastAddr, 20'h00300)
      waitN(base + 8'h2);
      `CHK(lastAddr, 20'h00400)
      `CHK(lastData, pat(20'h10010))
      pulse(0);
      waitN(base + 8'h3);
      `CHK(lastAddr, 20'h00402)
      repeat (4) @(posedge sys_clk);
      `CHK(doneCnt[1], 2)
      // every hardware trigger select code of channel zero, codes 1 to 15
      axw(ra(1, CTD_OFF_CTRL), 32'h0);
      setup(0, 20'h10000, 20'h00500, 16'h0000, 32'h5);
      for (int s = 1; s < 16; s++) begin
         axw(ra(0, CTD_OFF_CTRL), 32'h5 | (32'(s) << 8));
         base = wrCount;
         if (s == 1) begin
            extIrqInOneN <= 1'b0;
            repeat (4) @(posedge sys_clk);
            extIrqInOneN <= 1'b1;
            waitN(base + 8'h1);
            `CHK(wrCount, base)
            extIrqInZeroN <= 1'b0;
            repeat (4) @(posedge sys_clk);
            extIrqInZeroN <= 1'b1;
         end else begin
            pulse(s < 12 ? s - 2 : (s == 12 ? CTD_PERI_SER1TX : s - 1));
         end
         waitN(base + 8'h1);
         `CHK(wrCount, base + 8'h1)
      end
      // channel one on serial one hears only receive; a slow bus merges bursts
      axw(ra(0, CTD_OFF_CTRL), 32'h0);
      axw(ra(1, CTD_OFF_CTRL), 32'hC17);
      base = wrCount;
      pulse(CTD_PERI_SER1TX);
      waitN(base + 8'h1);
      `CHK(wrCount, base)
      slowDly <= 2'h3;
      pulse(CTD_PERI_SER1RX);
      pulse(CTD_PERI_SER1RX);
      pulse(CTD_PERI_SER1RX);
      waitN(base + 8'h3);
      `CHK(wrCount, base + 8'h2)
      wrapUp();
   end
endmodule
`default_nettype wire
